// File: logic/dcc_channel.sv
// One comparator channel: result synchroniser, change flag, settle timer.
// Assumes raw_i is asynchronous; all else on clk.
`timescale 1ns/100ps
`include "dcc_consts.svh"

module dcc_channel
  import dcc_pkg::*;
#(
  parameter int SETTLE_CYC = (`DCC_SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en_i,
  input  wire logic raw_i,
  input  wire logic sw_clr_i,
  output logic      res_o,
  output logic      flag_o,
  output logic      change_o,
  output logic      settled_o,
  output logic      settle_evt_o
);

  localparam int CW = $clog2(SETTLE_CYC + 1);

  if (SETTLE_CYC < 1) begin : g_chk
    $error("SETTLE_CYC must be at least one");
  end

  logic          meta_q, meta_d;
  logic          sync_q, sync_d;
  logic          res_q, res_d;
  logic          flag_q, flag_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          change;
  logic          settle_evt;

  // =============================================
  // Synchroniser, change detect, settle timer
  always_comb begin
    meta_d = raw_i;
    sync_d = meta_q;
    res_d  = en_i ? sync_q : 1'h0;
    change = en_i && (sync_q != res_q);
    if (!en_i) begin
      flag_d = 1'h0;
    end else begin
      flag_d = change | (flag_q & ~sw_clr_i);
    end
    settle_evt = 1'h0;
    if (!en_i) begin
      cnt_d = '0;
    end else if (cnt_q != CW'(SETTLE_CYC)) begin
      cnt_d = cnt_q + CW'(1);
      settle_evt = (cnt_q == CW'(SETTLE_CYC - 1));
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      res_q  <= 1'h0;
      flag_q <= 1'h0;
      cnt_q  <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      res_q  <= res_d;
      flag_q <= flag_d;
      cnt_q  <= cnt_d;
    end
  end

  assign res_o        = res_q;
  assign flag_o       = flag_q;
  assign change_o     = change;
  assign settled_o    = (cnt_q == CW'(SETTLE_CYC));
  assign settle_evt_o = settle_evt;

  // =============================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_change_sets_flag: assert property (
    change |=> flag_q) else $error("change did not set flag");
  a_disable_clears: assert property (
    !en_i |=> !flag_q && !res_q) else $error("disabled channel not clear");
  a_two_stage_sync: assert property (
    $past(en_i) && $past(en_i, 2) |-> res_q == $past(raw_i, 3))
    else $error("result not three cycles behind raw input");
  a_settle_hold: assert property (
    $rose(en_i) |-> !settled_o [*8]) else $error("settled too early");
  a_clear_loses: assert property (
    change && sw_clr_i |=> flag_q) else $error("clear beat change");

  c_flag_set: cover property (en_i ##1 $rose(flag_q));
  c_settled:  cover property (settle_evt);

endmodule

// File: logic/dcc_consts.svh
// Constants of the dual comparator control block.
// Included by the top and channel design files; definitions only.
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// =============================================
// Register indices, byte address is four times
`define DCC_ADDR_W      12
`define DCC_CTL1_IDX    10'h0AC
`define DCC_CTL2_IDX    10'h0AD
`define DCC_STAT_IDX    10'h0B0
`define DCC_MASK_IDX    10'h0B1
`define DCC_IEN_IDX     10'h0B2
`define DCC_STATE_IDX   10'h0B3

// =============================================
// Control register fields
`define DCC_BIT_EN      5
`define DCC_BIT_POS     4
`define DCC_BIT_NEG     3
`define DCC_BIT_OE      2
`define DCC_BIT_RES     1
`define DCC_BIT_FLAG    0
`define DCC_CTL_RST     8'h00
`define DCC_CTL_WMASK   8'h3C

// =============================================
// Interrupt registers
`define DCC_IEN_GLB     2
`define DCC_IRQ_W       4
`define DCC_IEN_W       3

// =============================================
// Bus answers and timing
`define DCC_RESP_OK     2'h0
`define DCC_RESP_DEC    2'h3
`define DCC_SETTLE_NS   10000
`define DCC_CLK_NS      8

`endif

// File: logic/dcc_pkg.sv
// Types of the dual comparator control block.
// Shared by the top module and the channel module.
package dcc_pkg;

  typedef enum logic [0:0] {
    WS_COLLECT = 1'h0,
    WS_RESP    = 1'h1
  } dcc_wr_st_t;

  typedef enum logic [0:0] {
    RS_IDLE = 1'h0,
    RS_DATA = 1'h1
  } dcc_rd_st_t;

  typedef enum logic [2:0] {
    SEL_CTL1  = 3'h0,
    SEL_CTL2  = 3'h1,
    SEL_STAT  = 3'h2,
    SEL_MASK  = 3'h3,
    SEL_IEN   = 3'h4,
    SEL_STATE = 3'h5,
    SEL_NONE  = 3'h7
  } dcc_sel_t;

endpackage

// File: logic/dcc_top.sv
// Dual comparator control block with AXI4-Lite register slave.
// Assumes one clock; analog results arrive asynchronously on CMP_RAW.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dcc_consts.svh"

module dcc_top
  import dcc_pkg::*;
#(
  parameter int SETTLE_CYC = (`DCC_SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  input  wire logic [`DCC_ADDR_W-1:0] AWADDR,
  input  wire logic                  AWVALID,
  output logic                       AWREADY,
  input  wire logic [31:0]           WDATA,
  input  wire logic [3:0]            WSTRB,
  input  wire logic                  WVALID,
  output logic                       WREADY,
  output logic [1:0]                 BRESP,
  output logic                       BVALID,
  input  wire logic                  BREADY,
  input  wire logic [`DCC_ADDR_W-1:0] ARADDR,
  input  wire logic                  ARVALID,
  output logic                       ARREADY,
  output logic [31:0]                RDATA,
  output logic [1:0]                 RRESP,
  output logic                       RVALID,
  input  wire logic                  RREADY,
  input  wire logic [1:0]            CMP_RAW,
  input  wire logic                  SLEEP,
  output logic [1:0]                 CMP_ON,
  output logic [1:0]                 POS_SEL,
  output logic [1:0]                 NEG_SEL,
  output logic [1:0]                 PIN_OE_N,
  output logic [1:0]                 PIN_OUT,
  output logic                       IRQ,
  output logic                       WAKE
);

  if (SETTLE_CYC < 1) begin : g_chk
    $error("SETTLE_CYC must be at least one");
  end

  // =============================================
  // Address decode, shared by both directions
  function automatic dcc_sel_t dcc_decode(
    input logic [`DCC_ADDR_W-1:0] a
  );
    case (a[`DCC_ADDR_W-1:2])
      `DCC_CTL1_IDX:  return SEL_CTL1;
      `DCC_CTL2_IDX:  return SEL_CTL2;
      `DCC_STAT_IDX:  return SEL_STAT;
      `DCC_MASK_IDX:  return SEL_MASK;
      `DCC_IEN_IDX:   return SEL_IEN;
      `DCC_STATE_IDX: return SEL_STATE;
      default:        return SEL_NONE;
    endcase
  endfunction

  // =============================================
  // Declarations
  dcc_wr_st_t               wr_st_q, wr_st_d;
  dcc_rd_st_t               rd_st_q, rd_st_d;
  logic                     aw_got_q, aw_got_d;
  logic                     w_got_q, w_got_d;
  logic [`DCC_ADDR_W-1:0]   waddr_q, waddr_d;
  logic [7:0]               wdata_q, wdata_d;
  logic                     wbyte_q, wbyte_d;
  logic                     awready_q, awready_d;
  logic                     wready_q, wready_d;
  logic                     bvalid_q, bvalid_d;
  logic [1:0]               bresp_q, bresp_d;
  logic                     arready_q, arready_d;
  logic                     rvalid_q, rvalid_d;
  logic [1:0]               rresp_q, rresp_d;
  logic [31:0]              rdata_q, rdata_d;
  logic                     do_wr;
  dcc_sel_t                 wsel;
  dcc_sel_t                 rsel;

  logic [7:0]               ctl_q [2];
  logic [7:0]               ctl_d [2];
  logic [`DCC_IRQ_W-1:0]    stat_q, stat_d;
  logic [`DCC_IRQ_W-1:0]    mask_q, mask_d;
  logic [`DCC_IEN_W-1:0]    ien_q, ien_d;
  logic [1:0]               oe_n_q, oe_n_d;
  logic                     irq_q, irq_d;
  logic                     wake_q, wake_d;
  logic                     irq_req;

  logic [1:0]               res;
  logic [1:0]               flag;
  logic [1:0]               change;
  logic [1:0]               settled;
  logic [1:0]               settle_evt;
  logic [1:0]               sw_clr;
  logic [1:0]               ch_en;
  logic [7:0]               rd_ctl [2];

  // =============================================
  // Channels
  for (genvar n = 0; n < 2; n++) begin : g_ch
    dcc_channel #(
      .SETTLE_CYC (SETTLE_CYC)
    ) u_ch (
      .clk          (CLOCK),
      .rst          (RST),
      .en_i         (ch_en[n]),
      .raw_i        (CMP_RAW[n]),
      .sw_clr_i     (sw_clr[n]),
      .res_o        (res[n]),
      .flag_o       (flag[n]),
      .change_o     (change[n]),
      .settled_o    (settled[n]),
      .settle_evt_o (settle_evt[n])
    );
    assign ch_en[n]   = ctl_q[n][`DCC_BIT_EN];
    assign CMP_ON[n]  = ctl_q[n][`DCC_BIT_EN];
    assign POS_SEL[n] = ctl_q[n][`DCC_BIT_POS];
    assign NEG_SEL[n] = ctl_q[n][`DCC_BIT_NEG];
    assign PIN_OUT[n] = CMP_RAW[n] & ~oe_n_q[n];
    assign rd_ctl[n]  = {2'h0, ctl_q[n][5:2], res[n], flag[n]};
  end

  // =============================================
  // Write channel: address and data in either order
  always_comb begin
    wr_st_d  = wr_st_q;
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    wbyte_d  = wbyte_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    do_wr    = 1'h0;
    case (wr_st_q)
      WS_COLLECT: begin
        if (AWVALID && awready_q) begin
          aw_got_d = 1'h1;
          waddr_d  = AWADDR;
        end
        if (WVALID && wready_q) begin
          w_got_d = 1'h1;
          wdata_d = WDATA[7:0];
          wbyte_d = WSTRB[0];
        end
        if (aw_got_d && w_got_d) begin
          do_wr    = 1'h1;
          aw_got_d = 1'h0;
          w_got_d  = 1'h0;
          bvalid_d = 1'h1;
          bresp_d  = (dcc_decode(waddr_d) == SEL_NONE) ?
                     `DCC_RESP_DEC : `DCC_RESP_OK;
          wr_st_d  = WS_RESP;
        end
      end
      WS_RESP: begin
        if (BREADY) begin
          bvalid_d = 1'h0;
          wr_st_d  = WS_COLLECT;
        end
      end
      default: wr_st_d = WS_COLLECT;
    endcase
    awready_d = (wr_st_d == WS_COLLECT) && !aw_got_d;
    wready_d  = (wr_st_d == WS_COLLECT) && !w_got_d;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_st_q   <= WS_COLLECT;
      aw_got_q  <= 1'h0;
      w_got_q   <= 1'h0;
      waddr_q   <= '0;
      wdata_q   <= 8'h00;
      wbyte_q   <= 1'h0;
      bvalid_q  <= 1'h0;
      bresp_q   <= `DCC_RESP_OK;
      awready_q <= 1'h0;
      wready_q  <= 1'h0;
    end else begin
      wr_st_q   <= wr_st_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wbyte_q   <= wbyte_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
    end
  end

  assign wsel = dcc_decode(waddr_d);

  // =============================================
  // Read channel
  always_comb begin
    rd_st_d  = rd_st_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    rsel     = dcc_decode(ARADDR);
    case (rd_st_q)
      RS_IDLE: begin
        if (ARVALID && arready_q) begin
          rvalid_d = 1'h1;
          rresp_d  = `DCC_RESP_OK;
          rd_st_d  = RS_DATA;
          case (rsel)
            SEL_CTL1:  rdata_d = {24'h0, rd_ctl[0]};
            SEL_CTL2:  rdata_d = {24'h0, rd_ctl[1]};
            SEL_STAT:  rdata_d = {28'h0, stat_q};
            SEL_MASK:  rdata_d = {28'h0, mask_q};
            SEL_IEN:   rdata_d = {29'h0, ien_q};
            SEL_STATE: rdata_d = {30'h0, settled};
            default: begin
              rdata_d = 32'h0;
              rresp_d = `DCC_RESP_DEC;
            end
          endcase
        end
      end
      RS_DATA: begin
        if (RREADY) begin
          rvalid_d = 1'h0;
          rd_st_d  = RS_IDLE;
        end
      end
      default: rd_st_d = RS_IDLE;
    endcase
    arready_d = (rd_st_d == RS_IDLE);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_st_q   <= RS_IDLE;
      rvalid_q  <= 1'h0;
      rresp_q   <= `DCC_RESP_OK;
      rdata_q   <= 32'h0;
      arready_q <= 1'h0;
    end else begin
      rd_st_q   <= rd_st_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      arready_q <= arready_d;
    end
  end

  // =============================================
  // Registers, interrupt and pin control
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    ien_d  = ien_q;
    for (int n = 0; n < 2; n++) begin
      ctl_d[n]  = ctl_q[n];
      sw_clr[n] = 1'h0;
      if (do_wr && wbyte_d &&
          wsel == ((n == 0) ? SEL_CTL1 : SEL_CTL2)) begin
        ctl_d[n]  = (wdata_d & `DCC_CTL_WMASK);
        sw_clr[n] = !wdata_d[`DCC_BIT_FLAG];
      end
    end
    if (do_wr && wbyte_d) begin
      case (wsel)
        SEL_STAT: stat_d = stat_q & ~wdata_d[`DCC_IRQ_W-1:0];
        SEL_MASK: mask_d = wdata_d[`DCC_IRQ_W-1:0];
        SEL_IEN:  ien_d  = wdata_d[`DCC_IEN_W-1:0];
        default:  ;
      endcase
    end
    // Events set after the clear so a same-cycle event survives
    stat_d = stat_d | {settle_evt, change};
    for (int n = 0; n < 2; n++) begin
      oe_n_d[n] = ~(ctl_d[n][`DCC_BIT_EN] & ctl_d[n][`DCC_BIT_OE]);
    end
    irq_req = ien_q[`DCC_IEN_GLB] &
              (|(flag & ien_q[1:0]) | |(stat_q & mask_q));
    irq_d   = irq_req;
    wake_d  = irq_req & SLEEP;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctl_q[0] <= `DCC_CTL_RST;
      ctl_q[1] <= `DCC_CTL_RST;
      stat_q   <= '0;
      mask_q   <= '0;
      ien_q    <= '0;
      oe_n_q   <= 2'h3;
      irq_q    <= 1'h0;
      wake_q   <= 1'h0;
    end else begin
      ctl_q[0] <= ctl_d[0];
      ctl_q[1] <= ctl_d[1];
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      ien_q    <= ien_d;
      oe_n_q   <= oe_n_d;
      irq_q    <= irq_d;
      wake_q   <= wake_d;
    end
  end

  assign AWREADY  = awready_q;
  assign WREADY   = wready_q;
  assign BVALID   = bvalid_q;
  assign BRESP    = bresp_q;
  assign ARREADY  = arready_q;
  assign RVALID   = rvalid_q;
  assign RRESP    = rresp_q;
  assign RDATA    = rdata_q;
  assign PIN_OE_N = oe_n_q;
  assign IRQ      = irq_q;
  assign WAKE     = wake_q;

  // =============================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_write_answer: assert property (
    do_wr |=> BVALID ##0 !AWREADY) else $error("write not answered");
  a_read_answer: assert property (
    ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read not answered");
  a_reserved_zero: assert property (
    RVALID |-> RDATA[31:6] == 26'h0) else $error("reserved bits set");
  a_byte_only: assert property (
    do_wr && !wbyte_d |=> $stable(ctl_q[0]) && $stable(ctl_q[1]))
    else $error("control changed without byte lane 0");
  a_irq_gated: assert property (
    IRQ |-> $past(ien_q[`DCC_IEN_GLB])) else $error("irq without global");
  a_irq_raised: assert property (
    ien_q[`DCC_IEN_GLB] && |(flag & ien_q[1:0]) |=> IRQ)
    else $error("enabled flag gave no irq");
  a_wake_sleep: assert property (
    WAKE |-> $past(SLEEP) && IRQ) else $error("wake outside sleep");
  a_pin_drive: assert property (
    !PIN_OE_N[0] |-> ctl_q[0][`DCC_BIT_EN] && ctl_q[0][`DCC_BIT_OE])
    else $error("pin driven while off");
  a_sticky_set: assert property (
    change[1] |=> stat_q[1]) else $error("event lost");

  c_irq:    cover property ($rose(IRQ));
  c_wake:   cover property ($rose(WAKE));
  c_wr_rd:  cover property (do_wr ##[1:20] RVALID);

endmodule

// File: test/dcc_analog_model.sv
// Behavioural model of the two analog comparator cores and their pins.
// Assumes the bench sets the pin levels; clk only paces the idle pattern.
`timescale 1ns/100ps

module dcc_analog_model #(
  parameter logic [7:0] INT_REF = 8'h80
) (
  input  wire logic        clk,
  input  wire logic [1:0]  on,
  input  wire logic [1:0]  pos_sel,
  input  wire logic [1:0]  neg_sel,
  input  wire logic [15:0] lvl_a,
  input  wire logic [15:0] lvl_b,
  input  wire logic [15:0] lvl_ref,
  output logic      [1:0]  raw
);
  logic       idle_q = 1'b0;
  logic [7:0] p [2];
  logic [7:0] n [2];

  // =============================================
  // Switched-off core gives a moving, meaningless level
  always @(posedge clk) begin
    idle_q <= !idle_q;
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      p[c] = pos_sel[c] ? lvl_b[8*c+:8] : lvl_a[8*c+:8];
      n[c] = neg_sel[c] ? INT_REF : lvl_ref[8*c+:8];
      raw[c] = on[c] ? (p[c] > n[c]) : (idle_q ^ c[0]);
    end
  end
endmodule

// File: test/dual_comparator_control_test.sv
// Self-checking bench of the dual comparator control block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/100ps
`include "dcc_consts.svh"
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end

module dual_comparator_control_test;
  import dcc_pkg::*;
  localparam logic [11:0] A_CTL1  = {`DCC_CTL1_IDX, 2'h0};
  localparam logic [11:0] A_CTL2  = {`DCC_CTL2_IDX, 2'h0};
  localparam logic [11:0] A_STAT  = {`DCC_STAT_IDX, 2'h0};
  localparam logic [11:0] A_MASK  = {`DCC_MASK_IDX, 2'h0};
  localparam logic [11:0] A_IEN   = {`DCC_IEN_IDX, 2'h0};
  localparam logic [11:0] A_STATE = {`DCC_STATE_IDX, 2'h0};
  localparam logic [1:0]  OK      = `DCC_RESP_OK;
  localparam logic [1:0]  DE      = `DCC_RESP_DEC;

  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  v;
    logic [3:0]  s;
    logic [1:0]  b;
    logic [31:0] e;
    logic [1:0]  re;
    logic [5:0]  p;
  } dcc_row_t;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        sleep = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [15:0] lvl_a = 16'h30A0;
  logic [15:0] lvl_b = 16'hC060;
  logic [15:0] lvl_ref = 16'h5050;
  logic        awready, wready, bvalid, arready, rvalid, irq, wake;
  logic [1:0]  bresp, rresp, cmp_raw, cmp_on, pos_sel, neg_sel;
  logic [1:0]  pin_oe_n, pin_out, r;
  logic [31:0] rdata, d;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  dcc_row_t    rows [10] = '{
    '{A_CTL1, 8'h1C, 4'h1, OK, 32'h1C, OK, 6'h17},
    '{A_CTL2, 8'h14, 4'h1, OK, 32'h14, OK, 6'h37},
    '{A_CTL1, 8'h08, 4'h0, OK, 32'h1C, OK, 6'h37},
    '{12'h100, 8'h55, 4'h1, DE, 32'h0, DE, 6'h37},
    '{A_IEN, 8'h07, 4'h1, OK, 32'h07, OK, 6'h37},
    '{A_IEN, 8'h00, 4'h1, OK, 32'h00, OK, 6'h37},
    '{A_MASK, 8'h05, 4'h1, OK, 32'h05, OK, 6'h37},
    '{A_MASK, 8'h00, 4'h1, OK, 32'h00, OK, 6'h37},
    '{A_CTL1, 8'h00, 4'h1, OK, 32'h00, OK, 6'h23},
    '{A_CTL2, 8'h00, 4'h1, OK, 32'h00, OK, 6'h03}};

  dcc_top #(.SETTLE_CYC(8)) dcc_top_i (
    .CLOCK(clock), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .CMP_RAW(cmp_raw),
    .SLEEP(sleep), .CMP_ON(cmp_on), .POS_SEL(pos_sel), .NEG_SEL(neg_sel),
    .PIN_OE_N(pin_oe_n), .PIN_OUT(pin_out), .IRQ(irq), .WAKE(wake));

  dcc_analog_model dcc_analog_model_i (
    .clk(clock), .on(cmp_on), .pos_sel(pos_sel), .neg_sel(neg_sel),
    .lvl_a(lvl_a), .lvl_b(lvl_b), .lvl_ref(lvl_ref), .raw(cmp_raw));

  // =============================================
  // Clock, hang guard and verdict
  always #4 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // =============================================
  // Bus master tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v,
                    input logic [3:0] s = 4'h1);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, v};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input logic [1:0] re = 2'h0);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    `CHK("rdata", e, d)
    `CHK("rresp", re, rresp)
  endtask

  // =============================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rdchk(A_CTL1, 32'h0);
    rdchk(A_CTL2, 32'h0);
    `CHK("oe_n", 2'h3, pin_oe_n)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].v, rows[i].s);
      `CHK("bresp", rows[i].b, r)
      rdchk(rows[i].a, rows[i].e, rows[i].re);
      `CHK("pins", rows[i].p, {pos_sel, neg_sel, pin_oe_n})
    end
    wr(A_CTL1, 8'h24);
    tick(8);
    `CHK("on", 2'h1, cmp_on)
    `CHK("oe_n", 2'h2, pin_oe_n)
    `CHK("pin", 2'h1, pin_out)
    rdchk(A_CTL1, 32'h27);
    rdchk(A_STATE, 32'h1);
    wr(A_CTL1, 8'h24);
    rdchk(A_CTL1, 32'h26);
    @(posedge clock);
    lvl_a[7:0] <= 8'h10;
    tick(6);
    `CHK("pin", 2'h0, pin_out)
    rdchk(A_CTL1, 32'h25);
    wr(A_CTL1, 8'h34);
    tick(6);
    rdchk(A_CTL1, 32'h37);
    wr(A_CTL1, 8'h3C);
    tick(6);
    rdchk(A_CTL1, 32'h3D);
    `CHK("sel", 4'h5, {pos_sel, neg_sel})
    wr(A_CTL1, 8'h3C);
    wr(A_IEN, 8'h01);
    @(posedge clock);
    lvl_b[7:0] <= 8'h90;
    tick(6);
    `CHK("irq", 1'b0, irq)
    wr(A_IEN, 8'h05);
    tick(2);
    `CHK("irq", 1'b1, irq)
    @(posedge clock);
    sleep <= 1'b1;
    tick(2);
    `CHK("wake", 1'b1, wake)
    wr(A_CTL1, 8'h3C);
    tick(2);
    `CHK("irq", 1'b0, irq)
    `CHK("wake", 1'b0, wake)
    @(posedge clock);
    sleep <= 1'b0;
    rdchk(A_STAT, 32'h5);
    wr(A_STAT, 8'h0F);
    rdchk(A_STAT, 32'h0);
    wr(A_MASK, 8'h01);
    wr(A_IEN, 8'h04);
    @(posedge clock);
    lvl_b[7:0] <= 8'h10;
    tick(6);
    `CHK("irq", 1'b1, irq)
    wr(A_STAT, 8'h01);
    tick(2);
    `CHK("irq", 1'b0, irq)
    wr(A_CTL1, 8'h1C);
    tick(2);
    rdchk(A_CTL1, 32'h1C);
    `CHK("oe_n", 2'h3, pin_oe_n)
    wr(A_CTL2, 8'h30);
    tick(8);
    rdchk(A_CTL2, 32'h33);
    rdchk(A_STATE, 32'h2);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdchk(A_CTL2, 32'h0);
    `CHK("on", 2'h0, cmp_on)
    stop_test();
  end
endmodule
